// ===== hw/csiprc_pkg.sv
// Shared constants and types for the camera link receive checker
package csiprc_pkg;
   // Register map
   localparam logic [7:0]  REG_ERR_COUNT = 8'h5c;
   localparam logic [7:0]  REG_ERR_FLAGS = 8'h5d;
   localparam logic [7:0]  REG_LANES01   = 8'h5e;
   localparam logic [7:0]  REG_LANES23   = 8'h5f;
   localparam logic [7:0]  REG_CLK_LANE  = 8'h60;
   localparam logic [7:0]  REG_CONTROL   = 8'h61;
   // Control register fields
   localparam int          CTL_ECC_ALARM = 0;
   localparam int          CTL_CRC_FWD   = 1;
   localparam int          CTL_LANES_LO  = 2;
   localparam int          CTL_CLEAR     = 7;
   localparam logic [7:0]  CTL_RESET     = 8'h0b;
   localparam logic [1:0]  LANES_1       = 2'h0;
   localparam logic [1:0]  LANES_2       = 2'h1;
   // Error flag fields
   localparam int          FLG_ECC1      = 0;
   localparam int          FLG_ECC2      = 1;
   localparam int          FLG_CRC       = 2;
   localparam int          FLG_SOT       = 3;
   localparam int          FLG_SOTSYNC   = 4;
   localparam int          FLG_OVERRUN   = 5;
   localparam int          CLK_HS        = 0;
   localparam int          CLK_LEN_CHG   = 1;
   localparam int          LANE_HI_OFS   = 4;
   localparam int          CLOCK_LANE    = 4;
   // Line states on {dp, dn}
   localparam logic [1:0]  LP11          = 2'h3;
   localparam logic [1:0]  LP01          = 2'h1;
   localparam logic [1:0]  LP00          = 2'h0;
   // Packet layer
   localparam logic [7:0]  SYNC_BYTE     = 8'hb8;
   localparam logic [5:0]  SHORT_MAX     = 6'h0f;
   localparam logic [5:0]  DT_FRAME_ON   = 6'h00;
   localparam logic [5:0]  DT_FRAME_OFF  = 6'h01;
   localparam logic [15:0] CRC_SEED      = 16'hffff;
   localparam logic [15:0] CRC_POLY      = 16'h8408;
   localparam logic [23:0] ECC_M0        = 24'hf12cb7;
   localparam logic [23:0] ECC_M1        = 24'hf2555b;
   localparam logic [23:0] ECC_M2        = 24'h749a6d;
   localparam logic [23:0] ECC_M3        = 24'hb8e38e;
   localparam logic [23:0] ECC_M4        = 24'hdf03f0;
   localparam logic [23:0] ECC_M5        = 24'heffc00;
   // Forward frame
   localparam logic [1:0]  FRAMING       = 2'h2;
   localparam logic [1:0]  FRAME_LAST    = 2'h3;
   localparam logic [4:0]  CRC5_SEED     = 5'h1f;
   localparam logic [4:0]  CRC5_POLY     = 5'h05;
   localparam logic signed [7:0] BODY_BITS = 8'sh25;

   typedef enum logic [1:0] {ST_STOP, ST_REQ, ST_HS} csiprc_lp_t;
   typedef enum logic [2:0] {P_HDR, P_PAY, P_FT0, P_FT1, P_DRAIN} csiprc_prs_t;
endpackage

// ===== hw/csiprc_top.sv
// Camera link receiver: lane states, packet checks, status and forward framer
// Function
// [R1] Accept one, two or four data lanes
// [R2] Receive only; escape signalling not supported
// [R3] LP-11, LP-01, LP-00 starts a burst
// [R4] Stay high-speed until LP-11 returns
// [R5] Enable termination during high-speed transfer
// [R6] Work with a continuously running clock lane
// [R7] Types 0x00 to 0x0F are short packets
// [R8] Frame start opens frame; long packets carry content
// [R9] Long packet: header, byte payload, 16-bit footer
// [R10] Header: identifier, word count, ECC in order
// [R11] Identifier yields virtual channel and type
// [R12] Word count gives the payload byte count
// [R13] ECC fixes one bit, flags two bits
// [R14] ECC error sets a sticky status bit
// [R15] Control bit gates the ECC alarm
// [R16] Payload checksum compared with the footer
// [R17] Checksum error flagged and forwarded
// [R18] Detect start and sync errors per lane
// [R19] Error count, lane and clock status
// [R20] Forward frames are exactly 40 bits
// [R21] Frames DC balanced with guaranteed transitions
// [R22] Frame holds payload, control, CRC, framing, state
// [R23] Checksum is CRC-16, seed ones, low byte first
`timescale 1ns/1ps
module csiprc_top (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_link_clock,
   input  wire logic [4:0]  i_lp_dp,
   input  wire logic [4:0]  i_lp_dn,
   input  wire logic [31:0] i_hs_byte,
   input  wire logic [3:0]  i_hs_valid,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_read,
   input  wire logic        i_reg_write,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic [7:0]  i_ctrl_data,
   input  wire logic        i_ctrl_valid,
   output logic      [4:0]  o_hs_term,
   output logic      [7:0]  o_reg_rdata,
   output logic             o_reg_rvalid,
   output logic             o_ctrl_taken,
   output logic      [39:0] o_fwd_frame,
   output logic             o_fwd_valid
);
   function automatic logic [3:0] lane_mask(input logic [1:0] code);
      lane_mask = (code == csiprc_pkg::LANES_1) ? 4'h1 :
                  (code == csiprc_pkg::LANES_2) ? 4'h3 : 4'hf;
   endfunction

   function automatic logic [5:0] ecc6(input logic [23:0] d);
      ecc6 = {^(d & csiprc_pkg::ECC_M5), ^(d & csiprc_pkg::ECC_M4),
              ^(d & csiprc_pkg::ECC_M3), ^(d & csiprc_pkg::ECC_M2),
              ^(d & csiprc_pkg::ECC_M1), ^(d & csiprc_pkg::ECC_M0)};
   endfunction

   function automatic logic [23:0] ecc_fix(input logic [5:0] syn);
      ecc_fix = 24'h000000;
      for (int k = 0; k < 24; k++) begin
         if (ecc6(24'h000001 << k) == syn) begin
            ecc_fix[k] = 1'b1;
         end
      end
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = (r >> 1) ^ (r[0] ? csiprc_pkg::CRC_POLY : 16'h0000);
      end
      crc_byte = r;
   endfunction

   function automatic logic [4:0] crc5(input logic [31:0] d);
      logic [4:0] c;
      logic       fb;
      c = csiprc_pkg::CRC5_SEED;
      for (int k = 0; k < 32; k++) begin
         fb = c[4] ^ d[k];
         c  = {c[3:0], 1'b0} ^ ({5{fb}} & csiprc_pkg::CRC5_POLY);
      end
      crc5 = c;
   endfunction

   function automatic logic [5:0] ones37(input logic [36:0] d);
      logic [5:0] n;
      n = 6'h00;
      for (int k = 0; k < 37; k++) begin
         n = n + {5'h00, d[k]};
      end
      ones37 = n;
   endfunction

   // Lane line-state tracking, clock lane at index 4
   for (genvar i = 0; i < 5; i++) begin : g_lp
      logic [1:0]             s1, s2;
      logic                   term;
      csiprc_pkg::csiprc_lp_t st, next_st;
      // Escape entry (LP-10) is never followed; only the HS entry is decoded
      always_comb begin
         next_st = st;
         case (st)
            csiprc_pkg::ST_STOP: begin
               if (s2 == csiprc_pkg::LP01) next_st = csiprc_pkg::ST_REQ; // R3 R2
            end
            csiprc_pkg::ST_REQ: begin
               if (s2 == csiprc_pkg::LP00) next_st = csiprc_pkg::ST_HS; // R3
               else if (s2 != csiprc_pkg::LP01) next_st = csiprc_pkg::ST_STOP;
            end
            csiprc_pkg::ST_HS: begin
               if (s2 == csiprc_pkg::LP11) next_st = csiprc_pkg::ST_STOP; // R4
            end
            default: next_st = csiprc_pkg::ST_STOP;
         endcase
      end
      always_ff @(posedge i_clock or posedge i_reset) begin
         if (i_reset) begin
            s1   <= csiprc_pkg::LP11;
            s2   <= csiprc_pkg::LP11;
            st   <= csiprc_pkg::ST_STOP;
            term <= 1'b0;
         end else begin
            s1   <= {i_lp_dp[i], i_lp_dn[i]};
            s2   <= s1;
            st   <= next_st;
            term <= (next_st == csiprc_pkg::ST_HS); // R5
         end
      end
      assign o_hs_term[i] = term;
   end

   // Control register, read by both domains
   logic [7:0] ctrl;
   wire        wr_ctl = i_reg_write & (i_reg_addr == csiprc_pkg::REG_CONTROL);
   wire        clr    = wr_ctl & i_reg_wdata[csiprc_pkg::CTL_CLEAR];

   // ---------------- Link clock domain ----------------
   logic [1:0]  lc1, lc2;
   logic [3:0]  hs1, hs2, lk;
   logic        hs0_q;
   logic [31:0] ev_data;
   logic [2:0]  ev_cnt;
   logic        ev_end, ev_tog;
   logic [3:0]  ev_soe, ev_sse, soe, sse;
   wire  [3:0]  used = lane_mask(lc2); // R1
   wire  [2:0]  nlanes = {used[3], used[1] & ~used[3], ~used[1]};
   wire         beat = lk[0] & (&(lk | ~used)) & (&(i_hs_valid | ~used));
   wire         burst_end = hs0_q & ~hs2[0];
   wire         ev_fire = beat | burst_end | (|soe) | (|sse);

   for (genvar i = 0; i < 4; i++) begin : g_sot
      logic      lk_b;
      wire [7:0] df   = i_hs_byte[8*i +: 8] ^ csiprc_pkg::SYNC_BYTE;
      wire       one  = (df != 8'h00) & ((df & (df - 8'h01)) == 8'h00);
      wire       seek = hs2[i] & ~lk_b & i_hs_valid[i] & used[i];
      assign soe[i] = seek & one; // R18
      assign sse[i] = seek & (df != 8'h00) & ~one; // R18
      always_ff @(posedge i_link_clock or posedge i_reset) begin
         if (i_reset) begin
            lk_b <= 1'b0;
         end else begin
            lk_b <= hs2[i] & (lk_b | (seek & ~sse[i]));
         end
      end
      assign lk[i] = lk_b;
   end

   // Byte clock taken from the clock lane; no lane-state edge is needed here
   always_ff @(posedge i_link_clock or posedge i_reset) begin // R6
      if (i_reset) begin
         lc1     <= 2'h0;
         lc2     <= 2'h0;
         hs1     <= 4'h0;
         hs2     <= 4'h0;
         hs0_q   <= 1'b0;
         ev_data <= 32'h00000000;
         ev_cnt  <= 3'h0;
         ev_end  <= 1'b0;
         ev_soe  <= 4'h0;
         ev_sse  <= 4'h0;
         ev_tog  <= 1'b0;
      end else begin
         lc1   <= ctrl[csiprc_pkg::CTL_LANES_LO +: 2];
         lc2   <= lc1;
         hs1   <= o_hs_term[3:0];
         hs2   <= hs1;
         hs0_q <= hs2[0];
         if (ev_fire) begin
            ev_data <= i_hs_byte;
            ev_cnt  <= beat ? nlanes : 3'h0;
            ev_end  <= burst_end;
            ev_soe  <= soe;
            ev_sse  <= sse;
            ev_tog  <= ~ev_tog;
         end
      end
   end

   // ---------------- System clock domain ----------------
   // Event words are held for a full byte clock, so a toggle crossing suffices
   logic        t1, t2, t3;
   wire         ev_new = t2 ^ t3;
   logic [31:0] hold;
   logic [2:0]  hold_cnt;
   logic        end_pend;
   logic [15:0] pair;
   logic [1:0]  pair_cnt;
   logic [1:0]  fcnt;
   wire         launch = (fcnt == 2'h0);
   wire         pop = (hold_cnt != 3'h0) & (pair_cnt != 2'h2) & ~ev_new;
   wire  [7:0]  cur = hold[7:0];

   csiprc_pkg::csiprc_prs_t ps, next_ps;
   logic [1:0]  hdr_idx;
   logic [23:0] hdr;
   logic [15:0] pay_left, crc, prev_wc;
   logic [7:0]  foot_lo;
   logic        frame_on, wc_seen;

   // Header check on the fourth header byte
   wire [5:0]   syn   = ecc6(hdr) ^ cur[5:0]; // R13
   wire [23:0]  fmask = ecc_fix(syn);
   wire [23:0]  fixed = hdr ^ fmask; // R13
   wire         e_one = (syn != 6'h00) & ((fmask != 24'h000000) | ((syn & (syn - 6'h01)) == 6'h00));
   wire         hdr_done = pop & (ps == csiprc_pkg::P_HDR) & (hdr_idx == 2'h3);
   wire         ecc1 = hdr_done & e_one;
   wire         ecc2 = hdr_done & (syn != 6'h00) & ~e_one;
   wire [1:0]   vch  = fixed[7:6]; // R11
   wire [5:0]   ptype = fixed[5:0]; // R11
   wire [15:0]  wc   = fixed[23:8]; // R10
   wire         is_short = ptype <= csiprc_pkg::SHORT_MAX; // R7
   wire         long_ok = hdr_done & ~ecc2 & ~is_short;
   wire         pay_push = pop & (ps == csiprc_pkg::P_PAY);
   wire         crc_err = pop & (ps == csiprc_pkg::P_FT1) & ({cur, foot_lo} != crc); // R16 R23
   wire         len_chg = long_ok & wc_seen & (wc != prev_wc);

   always_comb begin
      next_ps = ps;
      case (ps)
         csiprc_pkg::P_HDR: begin
            if (hdr_done) begin
               if (ecc2 | is_short) next_ps = csiprc_pkg::P_DRAIN; // R7 R13
               else if (wc == 16'h0000) next_ps = csiprc_pkg::P_FT0;
               else next_ps = csiprc_pkg::P_PAY; // R9
            end
         end
         csiprc_pkg::P_PAY: begin
            if (pop & (pay_left == 16'h0001)) next_ps = csiprc_pkg::P_FT0; // R12
         end
         csiprc_pkg::P_FT0: begin
            if (pop) next_ps = csiprc_pkg::P_FT1;
         end
         csiprc_pkg::P_FT1: begin
            if (pop) next_ps = csiprc_pkg::P_DRAIN;
         end
         default: next_ps = ps;
      endcase
      if (end_pend & (hold_cnt == 3'h0)) next_ps = csiprc_pkg::P_HDR;
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         t1       <= 1'b0;
         t2       <= 1'b0;
         t3       <= 1'b0;
         hold     <= 32'h00000000;
         hold_cnt <= 3'h0;
         end_pend <= 1'b0;
      end else begin
         t1 <= ev_tog;
         t2 <= t1;
         t3 <= t2;
         if (ev_new) begin
            hold     <= ev_data;
            hold_cnt <= ev_cnt;
            end_pend <= end_pend | ev_end;
         end else if (pop) begin
            hold     <= {8'h00, hold[31:8]};
            hold_cnt <= hold_cnt - 3'h1;
         end else if (hold_cnt == 3'h0) begin
            end_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         ps       <= csiprc_pkg::P_HDR;
         hdr_idx  <= 2'h0;
         hdr      <= 24'h000000;
         pay_left <= 16'h0000;
         crc      <= csiprc_pkg::CRC_SEED;
         foot_lo  <= 8'h00;
         frame_on <= 1'b0;
         wc_seen  <= 1'b0;
         prev_wc  <= 16'h0000;
      end else begin
         ps <= next_ps;
         if (next_ps == csiprc_pkg::P_HDR && ps != csiprc_pkg::P_HDR) begin
            hdr_idx <= 2'h0;
         end else if (pop & (ps == csiprc_pkg::P_HDR)) begin
            hdr     <= {cur, hdr[23:8]}; // R10
            hdr_idx <= hdr_idx + 2'h1;
         end
         if (long_ok) begin
            pay_left <= wc; // R12
            crc      <= csiprc_pkg::CRC_SEED; // R23
            wc_seen  <= 1'b1;
            prev_wc  <= wc;
         end else if (pay_push) begin
            pay_left <= pay_left - 16'h0001;
            crc      <= crc_byte(crc, cur); // R16 R23
         end
         if (pop & (ps == csiprc_pkg::P_FT0)) foot_lo <= cur; // R23
         if (hdr_done & ~ecc2 & (ptype == csiprc_pkg::DT_FRAME_ON)) begin
            frame_on <= 1'b1; // R8
            wc_seen  <= 1'b0;
         end else if (hdr_done & ~ecc2 & (ptype == csiprc_pkg::DT_FRAME_OFF)) begin
            frame_on <= 1'b0;
         end
      end
   end

   // Status and registers; a set in the clear cycle wins
   logic [7:0] err_cnt, flags, lanes01, lanes23, clk_st;
   wire  [3:0] soe_s = ev_new ? ev_soe : 4'h0;
   wire  [3:0] sse_s = ev_new ? ev_sse : 4'h0;
   wire        overrun = ev_new & (hold_cnt != 3'h0);
   wire        any_err = ecc1 | ecc2 | crc_err | (|soe_s) | (|sse_s);
   wire  [7:0] flag_set = {2'h0, overrun, |sse_s, |soe_s, crc_err, ecc2, ecc1};
   wire  [7:0] l01_set = {2'h0, sse_s[1], soe_s[1], 2'h0, sse_s[0], soe_s[0]};
   wire  [7:0] l23_set = {2'h0, sse_s[3], soe_s[3], 2'h0, sse_s[2], soe_s[2]};
   wire  [7:0] keep = clr ? 8'h00 : 8'hff;
   wire        ecc_alarm = ctrl[csiprc_pkg::CTL_ECC_ALARM] &
                           (flags[csiprc_pkg::FLG_ECC1] | flags[csiprc_pkg::FLG_ECC2]);
   wire        crc_alarm = ctrl[csiprc_pkg::CTL_CRC_FWD] & flags[csiprc_pkg::FLG_CRC];
   wire  [7:0] rd_mux =
      (i_reg_addr == csiprc_pkg::REG_ERR_COUNT) ? err_cnt :
      (i_reg_addr == csiprc_pkg::REG_ERR_FLAGS) ? flags :
      (i_reg_addr == csiprc_pkg::REG_LANES01)   ? lanes01 :
      (i_reg_addr == csiprc_pkg::REG_LANES23)   ? lanes23 :
      (i_reg_addr == csiprc_pkg::REG_CLK_LANE)  ? clk_st :
      (i_reg_addr == csiprc_pkg::REG_CONTROL)   ? ctrl : 8'h00;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         ctrl         <= csiprc_pkg::CTL_RESET;
         err_cnt      <= 8'h00;
         flags        <= 8'h00;
         lanes01      <= 8'h00;
         lanes23      <= 8'h00;
         clk_st       <= 8'h00;
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         if (wr_ctl) ctrl <= i_reg_wdata & ~(8'h01 << csiprc_pkg::CTL_CLEAR); // R15 R1
         if (any_err & (err_cnt != 8'hff)) err_cnt <= err_cnt + 8'h01; // R19
         else err_cnt <= err_cnt & keep;
         flags   <= (flags & keep) | flag_set; // R14 R17 R18
         lanes01 <= (lanes01 & keep) | l01_set; // R19
         lanes23 <= (lanes23 & keep) | l23_set; // R19
         clk_st[csiprc_pkg::CLK_HS] <= o_hs_term[csiprc_pkg::CLOCK_LANE];
         clk_st[csiprc_pkg::CLK_LEN_CHG] <= (clk_st[csiprc_pkg::CLK_LEN_CHG] & ~clr) | len_chg;
         o_reg_rvalid <= i_reg_read;
         if (i_reg_read) o_reg_rdata <= rd_mux;
      end
   end

   // Forward framer: one 40-bit frame every four cycles, up to two payload bytes each
   logic signed [7:0] rd;
   wire  [4:0]  state = {o_hs_term[0], crc_alarm, ecc_alarm, frame_on,
                         o_hs_term[csiprc_pkg::CLOCK_LANE]}; // R15 R17
   wire  [31:0] content = {state, i_ctrl_valid, i_ctrl_data, pair_cnt, pair}; // R22
   wire  [36:0] body = {crc5(content), content}; // R22
   wire  signed [7:0] disp = $signed({1'b0, ones37(body), 1'b0}) - csiprc_pkg::BODY_BITS;
   wire         inv = (rd >= 8'sh00) == (disp > 8'sh00); // R21
   wire  signed [7:0] next_rd = inv ? (rd - disp + 8'sh01) : (rd + disp - 8'sh01);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         fcnt         <= 2'h0;
         rd           <= 8'sh00;
         pair         <= 16'h0000;
         pair_cnt     <= 2'h0;
         o_fwd_frame  <= 40'h0000000000;
         o_fwd_valid  <= 1'b0;
         o_ctrl_taken <= 1'b0;
      end else begin
         fcnt         <= (fcnt == csiprc_pkg::FRAME_LAST) ? 2'h0 : fcnt + 2'h1; // R20
         o_fwd_valid  <= launch;
         o_ctrl_taken <= launch & i_ctrl_valid;
         if (launch) begin
            o_fwd_frame <= {csiprc_pkg::FRAMING, inv, body ^ {37{inv}}}; // R20 R21
            rd          <= next_rd;
         end
         if (launch) begin
            pair     <= pay_push ? {8'h00, cur} : 16'h0000;
            pair_cnt <= pay_push ? 2'h1 : 2'h0;
         end else if (pay_push) begin
            pair     <= (pair_cnt == 2'h0) ? {8'h00, cur} : {cur, pair[7:0]};
            pair_cnt <= pair_cnt + 2'h1;
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_hs_entry: assert property ($rose(o_hs_term[0]) |-> $past(g_lp[0].s2) == csiprc_pkg::LP00 && $past(g_lp[0].st) == csiprc_pkg::ST_REQ) else $error("HS entered without LP-01, LP-00"); // R3
   a_hs_hold: assert property (o_hs_term[0] && g_lp[0].s2 != csiprc_pkg::LP11 |=> o_hs_term[0]) else $error("HS left before stop state"); // R4
   a_hs_exit: assert property (o_hs_term[0] && g_lp[0].s2 == csiprc_pkg::LP11 |=> !o_hs_term[0]) else $error("HS kept after stop state"); // R5
   a_ecc_sticky: assert property (ecc1 || ecc2 |=> flags[csiprc_pkg::FLG_ECC1] || flags[csiprc_pkg::FLG_ECC2]) else $error("ECC error not recorded"); // R14
   a_alarm_gate: assert property (!ctrl[csiprc_pkg::CTL_ECC_ALARM] |-> !state[2]) else $error("ECC alarm sent while disabled"); // R15
   a_crc_flag: assert property (crc_err |=> flags[csiprc_pkg::FLG_CRC]) else $error("Checksum error not flagged"); // R17
   a_short_drain: assert property (hdr_done && !ecc2 && is_short && !(end_pend && hold_cnt == 3'h1) |=> ps == csiprc_pkg::P_DRAIN) else $error("Short packet not closed"); // R7
   a_frame_gap: assert property (o_fwd_valid |=> !o_fwd_valid [*3] ##1 o_fwd_valid) else $error("Frame spacing wrong"); // R20
   a_frame_mark: assert property (o_fwd_valid |-> o_fwd_frame[39:38] == csiprc_pkg::FRAMING) else $error("Framing bits missing"); // R21
   a_err_count: assert property (any_err && err_cnt != 8'hff |=> err_cnt == $past(err_cnt) + 8'h01) else $error("Error count not advanced"); // R19
endmodule

// ===== verification/csiprc_sensor.sv
// Sensor transmitter model: lane entry sequence and one long packet per burst
`timescale 1ns/1ps
module csiprc_sensor (
   input  wire logic        i_link_clock,
   output logic      [4:0]  o_lp_dp,
   output logic      [4:0]  o_lp_dn,
   output logic      [31:0] o_hs_byte,
   output logic      [3:0]  o_hs_valid
);
   logic clk_hs = 1'b0;
   initial begin
      o_lp_dp = 5'h1f;
      o_lp_dn = 5'h1f;
      o_hs_byte = 32'h0;
      o_hs_valid = 4'h0;
   end
   // Clock lane enters high-speed once and never leaves
   task automatic lp(input logic [1:0] s);
      @(posedge i_link_clock) #1;
      o_lp_dp[0] = s[1];
      o_lp_dn[0] = s[0];
      if (!clk_hs) begin
         o_lp_dp[4] = s[1];
         o_lp_dn[4] = s[0];
      end
   endtask
   // Lanes 1 and 3 carry the inverse and lane 2 a copy; only lane 0 is flagged valid
   task automatic put(input logic [7:0] b);
      @(posedge i_link_clock) #1;
      o_hs_byte = {~b, b, ~b, b};
      o_hs_valid = 4'h1;
   endtask
   task automatic burst(input logic [7:0] sync, input logic [31:0] flip, input logic bad);
      logic [23:0] h;
      logic [31:0] w;
      logic [15:0] c;
      logic [7:0]  d;
      h = 24'h00042a;
      w = {2'h0, ^(h & csiprc_pkg::ECC_M5), ^(h & csiprc_pkg::ECC_M4),
           ^(h & csiprc_pkg::ECC_M3), ^(h & csiprc_pkg::ECC_M2),
           ^(h & csiprc_pkg::ECC_M1), ^(h & csiprc_pkg::ECC_M0), h} ^ flip;
      c = csiprc_pkg::CRC_SEED;
      lp(csiprc_pkg::LP11);
      lp(csiprc_pkg::LP01);
      lp(csiprc_pkg::LP00);
      clk_hs = 1'b1;
      repeat (6) @(posedge i_link_clock);
      put(sync);
      for (int i = 0; i < 4; i++) put(w[8*i +: 8]);
      for (int i = 0; i < 4; i++) begin
         d = 8'(17 * (i + 1));
         put(d);
         for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ d[k]) ? 16'h8408 : 16'h0);
      end
      c[0] = c[0] ^ bad;
      put(c[7:0]);
      put(c[15:8]);
      @(posedge i_link_clock) #1;
      o_hs_valid = 4'h0;
      o_hs_byte = ~o_hs_byte;
      lp(csiprc_pkg::LP11);
   endtask
endmodule

// ===== verification/testbench.sv
// Bench for the camera link receive checker: registers, bursts, forward frames
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic        i_link_clock = 1'b0;
   logic [4:0]  dp, dn, term;
   logic [31:0] hs;
   logic [3:0]  hv;
   logic [7:0]  addr = 8'h0, wdata = 8'h0, cdata = 8'h0, rdata;
   logic        rd_en = 1'b0, wr_en = 1'b0, cvalid = 1'b0, rvalid, taken, fv;
   logic [39:0] frame;
   int          n_mismatch = 0;
   int          checks_done = 0;
   csiprc_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_link_clock(i_link_clock),
      .i_lp_dp(dp), .i_lp_dn(dn), .i_hs_byte(hs), .i_hs_valid(hv), .i_reg_addr(addr),
      .i_reg_read(rd_en), .i_reg_write(wr_en), .i_reg_wdata(wdata), .i_ctrl_data(cdata),
      .i_ctrl_valid(cvalid), .o_hs_term(term), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .o_ctrl_taken(taken), .o_fwd_frame(frame), .o_fwd_valid(fv));
   csiprc_sensor sensor (.i_link_clock(i_link_clock), .o_lp_dp(dp), .o_lp_dn(dn),
      .o_hs_byte(hs), .o_hs_valid(hv));
   initial begin
      forever #2.5 i_clock = ~i_clock;
   end
   initial begin
      #7;
      forever #40 i_link_clock = ~i_link_clock;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge i_clock) #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge i_clock) #1;
      rd_en = 1'b0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata & m, e)
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock) #1;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge i_clock) #1;
      wr_en = 1'b0;
   endtask
   task automatic wait_for(ref logic s, input int lim);
      for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge i_clock);
      `CHK(s, 1'b1)
      if (s !== 1'b1) print_verdict;
   endtask
   task automatic burst(input logic [7:0] s, input logic [31:0] f, input logic b);
      fork
         sensor.burst(s, f, b);
         begin
            for (int n = 0; n < 400 && term[0] !== 1'b1; n++) @(negedge i_clock);
            `CHK(term, 5'h11)
         end
      join
      repeat (40) @(negedge i_clock);
      `CHK(term, 5'h10)
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      repeat (2) @(posedge i_link_clock);
      #1 i_reset = 1'b0;
      for (int a = 'h5c; a < 'h61; a++) rd(8'(a), 8'h00);
      rd(csiprc_pkg::REG_CONTROL, csiprc_pkg::CTL_RESET);
      rd(8'h70, 8'h00);
      wr(8'h5d, 8'hff);
      rd(8'h5d, 8'h00);
      $display("test registers done");
      wait_for(fv, 8);
      `CHK(frame[39:38], 2'h2)
      repeat (3) begin
         @(negedge i_clock);
         `CHK(fv, 1'b0)
      end
      @(negedge i_clock);
      `CHK(fv, 1'b1)
      @(posedge i_clock) #1;
      cdata = 8'h5a;
      cvalid = 1'b1;
      wait_for(taken, 40);
      `CHK({frame[26], frame[25:18]} ^ {9{frame[37]}}, 9'h15a)
      @(posedge i_clock) #1;
      cvalid = 1'b0;
      $display("test frames done");
      wr(8'h61, 8'h03);
      burst(8'hb8, 0, 0);
      rd(8'h5d, 8'h00);
      burst(8'hb8, 0, 1);
      rd(8'h5d, 8'h04);
      `CHK(frame[30] ^ frame[37], 1'b1)
      rd(8'h5c, 8'h01);
      burst(8'hb8, 32'h100, 0);
      rd(8'h5d, 8'h05);
      `CHK(frame[29] ^ frame[37], 1'b1)
      burst(8'hb8, 32'h300, 0);
      rd(8'h5d, 8'h07);
      wr(8'h61, 8'h83);
      rd(8'h5d, 8'h00);
      rd(8'h61, 8'h03);
      $display("test packets done");
      burst(8'hb9, 0, 0);
      rd(8'h5d, 8'h08);
      rd(8'h5e, 8'h01);
      burst(8'h47, 0, 0);
      rd(8'h5d, 8'h18, 8'h18);
      $display("test start errors done");
      print_verdict;
   end
endmodule
